// ---- bench/btpc_far_end.sv ----
// Far-end model: clock source, serial data source and line receiver for the transmit block.
module btpc_far_end
(
    // Settings from the bench
    input wire logic sample_fall,
    input wire logic send_zeros,
    // Toward the block
    output logic src_clk,
    output logic serial_data,
    // Line side
    input wire logic line_clk,
    input wire logic line_out_positive,
    input wire logic line_out_negative,
    input wire logic line_out_oe_n,
    output int mark_count
);
    timeunit 1ns;
    timeprecision 100ps;

    // ====================================================================
    // Clock and data source
    // ====================================================================
    initial begin
        src_clk = 1'b0;
        serial_data = 1'b1;
        forever begin
            #83;
            src_clk = ~src_clk;
            // Data moves on the edge away from the sampling edge, so it is settled when taken.
            if (src_clk == sample_fall) begin
                serial_data = ~send_zeros;
            end
        end
    end

    // ====================================================================
    // Line receiver
    // ====================================================================
    initial mark_count = 0;
    always @(posedge line_clk) begin
        if (line_out_oe_n === 1'b0 && (line_out_positive === 1'b1 || line_out_negative === 1'b1)) begin
            mark_count <= mark_count + 1;
        end
    end
endmodule

// ---- bench/btpc_tx_pin_ctrl_bench.sv ----
// Self-checking bench for the transmit pin control block.
module btpc_tx_pin_ctrl_bench
    import btpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ====================================================================
    // Signals
    // ====================================================================
    logic ref_clk, nrst, line_clk, src_clk, serial_data;
    btpc_apb_req_t req;
    btpc_apb_rsp_t rsp;
    logic [NUM_OUT_CLOCKS:1] out_clk, clk_mask;
    logic aux_sel, tx_aux_input, tx_serial_data_in, frame_sync_in, mframe_sync_in;
    logic ovh_slot, ovh_bit, line_float_pin, inv_sel, send_zeros, edge_chk, last_clk;
    logic tx_clock_out, tx_clock_out_oe_n, tx_sync_out, tx_sync_out_oe_n;
    logic tx_bit_strobe, aux_sync_sample, line_out_positive, line_out_negative, line_out_oe_n;
    logic [31:0] rd;
    logic err;
    int mark_count, toggles, strobes, syncs, marks, bad_count, total_checks;
    logic [2:0] line_cases [4] = '{3'b001, 3'b000, 3'b101, 3'b011};

    btpc_tx_pin_ctrl i_btpc_tx_pin_ctrl (.ref_clk(ref_clk), .nrst(nrst), .line_clk(line_clk),
        .apb_req(req), .apb_rsp(rsp), .out_clk(out_clk), .tx_aux_input(tx_aux_input),
        .tx_serial_data_in(tx_serial_data_in), .frame_sync_in(frame_sync_in),
        .mframe_sync_in(mframe_sync_in), .ovh_slot(ovh_slot), .ovh_bit(ovh_bit),
        .tx_clock_out(tx_clock_out), .tx_clock_out_oe_n(tx_clock_out_oe_n),
        .tx_sync_out(tx_sync_out), .tx_sync_out_oe_n(tx_sync_out_oe_n),
        .tx_bit_strobe(tx_bit_strobe), .aux_sync_sample(aux_sync_sample),
        .line_float_pin(line_float_pin), .line_out_positive(line_out_positive),
        .line_out_negative(line_out_negative), .line_out_oe_n(line_out_oe_n));

    btpc_far_end i_btpc_far_end (.sample_fall(inv_sel), .send_zeros(send_zeros),
        .src_clk(src_clk), .serial_data(serial_data), .line_clk(line_clk),
        .line_out_positive(line_out_positive), .line_out_negative(line_out_negative),
        .line_out_oe_n(line_out_oe_n), .mark_count(mark_count));

    // ====================================================================
    // Clocks, pins and watchdog
    // ====================================================================
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        line_clk = 1'b0;
        #7;
        forever #24 line_clk = ~line_clk;
    end
    // Only the selected source carries a clock, so a wrong selection shows as a dead output.
    always @(posedge ref_clk) begin
        out_clk <= clk_mask & {NUM_OUT_CLOCKS{src_clk}};
        tx_aux_input <= aux_sel & src_clk;
        tx_serial_data_in <= serial_data;
    end
    always @(posedge ref_clk) begin
        if (tx_clock_out !== last_clk) toggles++;
        last_clk = tx_clock_out;
        if (aux_sync_sample === 1'b1) syncs++;
        if (tx_bit_strobe === 1'b1) begin
            strobes++;
            if (edge_chk === 1'b1) check("clock level at strobe", {31'h0, tx_clock_out}, {31'h0, ~inv_sel});
        end
    end
    initial begin
        #400000;
        bad_count++;
        close_out();
    end

    // ====================================================================
    // Tasks
    // ====================================================================
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= addr;
        req.pwdata <= wd;
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            close_out();
        end
    endtask

    task automatic chk_rd(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check("register read", rd, exp);
        check("register error", {31'h0, err}, 32'h0);
    endtask

    task automatic measure(input int n);
        int m0;
        repeat (50) @(posedge ref_clk);
        toggles = 0;
        strobes = 0;
        syncs = 0;
        m0 = mark_count;
        repeat (n) @(posedge ref_clk);
        marks = mark_count - m0;
    endtask

    // ====================================================================
    // Main sequence
    // ====================================================================
    initial begin
        nrst = 1'b0;
        req = '0;
        clk_mask = '0;
        out_clk = '0;
        {aux_sel, tx_aux_input, frame_sync_in, mframe_sync_in, ovh_slot, ovh_bit} = '0;
        {line_float_pin, inv_sel, send_zeros, edge_chk, last_clk} = '0;
        tx_serial_data_in = 1'b1;
        // Reset spans the slower clock so both domains see it.
        repeat (3) @(posedge line_clk);
        @(posedge ref_clk);
        nrst <= 1'b1;
        chk_rd(OFS_TX_PIN_CONTROL, 32'h0);
        chk_rd(OFS_CLOCK_SELECT_CONTROL, 32'(CLKSRC_RESET));
        chk_rd(OFS_LINE_INTERFACE_CONTROL, 32'h0);
        chk_rd(OFS_TRANSCEIVER_MODE_CONTROL, 32'(BTPC_MODE_DS1));
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, OFS_TX_PIN_CONTROL, 32'h1 << BIT_CLOCK_OUT_ENABLE);
        for (int c = 0; c < 10; c++) begin
            clk_mask <= (c == 0) ? '0 : NUM_OUT_CLOCKS'(1) << (c - 1);
            aux_sel <= (c == 0);
            apb(1'b1, OFS_CLOCK_SELECT_CONTROL, 32'(c));
            chk_rd(OFS_CLOCK_SELECT_CONTROL, 32'(c));
            measure(300);
            check("clock running", 32'(toggles > 10), 32'(c != 8));
            check("strobes seen", 32'(strobes > 5), 32'(c != 8));
        end
        check("clock drive", 32'(tx_clock_out_oe_n), 32'h0);
        clk_mask <= NUM_OUT_CLOCKS'(1);
        apb(1'b1, OFS_CLOCK_SELECT_CONTROL, 32'h1);
        apb(1'b1, OFS_TX_PIN_CONTROL, 32'h0);
        measure(100);
        check("clock idle", 32'(toggles), 32'h0);
        check("clock drive off", 32'(tx_clock_out_oe_n), 32'h1);
        for (int i = 0; i < 2; i++) begin
            inv_sel <= i[0];
            apb(1'b1, OFS_TX_PIN_CONTROL, (32'h1 << BIT_CLOCK_OUT_ENABLE) | (32'(i) << BIT_CLOCK_EDGE_INVERT));
            repeat (20) @(posedge ref_clk);
            edge_chk <= 1'b1;
            measure(300);
            edge_chk <= 1'b0;
            check("strobes seen", 32'(strobes > 5), 32'h1);
        end
        for (int s = 0; s < 4; s++) begin
            frame_sync_in <= s[0];
            mframe_sync_in <= ~s[0];
            apb(1'b1, OFS_TX_PIN_CONTROL, (32'h1 << BIT_SYNC_OUT_ENABLE) | (32'(s[1]) << BIT_SYNC_OUT_SOURCE));
            repeat (3) @(posedge ref_clk);
            check("sync out", {31'h0, tx_sync_out}, {31'h0, s[1] ^ s[0]});
            check("sync drive", 32'(tx_sync_out_oe_n), 32'h0);
        end
        apb(1'b1, OFS_TX_PIN_CONTROL, 32'h1 << BIT_CLOCK_OUT_ENABLE);
        repeat (3) @(posedge ref_clk);
        check("sync drive off", 32'(tx_sync_out_oe_n), 32'h1);
        // Each case is {float pin, power down, driver enable}; only the first drives the line.
        foreach (line_cases[k]) begin
            line_float_pin <= line_cases[k][2];
            apb(1'b1, OFS_LINE_INTERFACE_CONTROL, 32'(line_cases[k][1:0]));
            measure(100);
            check("line drive", 32'(line_out_oe_n), 32'(k != 0));
            check("line marks", 32'(marks > 0), 32'(k == 0));
        end
        apb(1'b1, OFS_LINE_INTERFACE_CONTROL, 32'h1 << BIT_LINE_DRIVER_ENABLE);
        send_zeros <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, OFS_TRANSCEIVER_MODE_CONTROL, 32'(m));
            measure(300);
            check("marks with zero data", 32'(marks > 0), 32'(m > 1));
        end
        ovh_slot <= 1'b1;
        ovh_bit <= 1'b1;
        apb(1'b1, OFS_TRANSCEIVER_MODE_CONTROL, 32'(BTPC_MODE_DS1));
        measure(300);
        check("inserted overhead marks", 32'(marks > 0), 32'h1);
        ovh_bit <= 1'b0;
        measure(300);
        check("inserted overhead spaces", 32'(marks), 32'h0);
        ovh_slot <= 1'b0;
        send_zeros <= 1'b0;
        measure(300);
        check("serial ones marks", 32'(marks > 0), 32'h1);
        // The aux pin follows the source clock, so it is high at rising edges and low at falling.
        aux_sel <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, OFS_TX_PIN_CONTROL,
                (32'h1 << BIT_AUX_SYNC_ENABLE) | (32'(i) << BIT_CLOCK_EDGE_INVERT));
            apb(1'b0, OFS_TX_STATUS, 32'h0);
            measure(200);
            check("aux sync pulses", 32'(syncs > 5), 32'(i == 0));
            apb(1'b0, OFS_TX_STATUS, 32'h0);
            check("aux sync seen", 32'(rd[STS_AUX_SYNC_SEEN]), 32'(i == 0));
            check("line active", 32'(rd[STS_LINE_ACTIVE]), 32'h1);
        end
        close_out();
    end
endmodule

// ---- core/btpc_pkg.sv ----
// Constants, register map and carrier types for the transmitter pin control block.
package btpc_pkg;

    // =====================================================================
    // Register map (byte addresses on the APB bus)
    // =====================================================================
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;
    localparam logic [7:0] OFS_TX_PIN_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CLOCK_SELECT_CONTROL = 8'h04;
    localparam logic [7:0] OFS_LINE_INTERFACE_CONTROL = 8'h08;
    localparam logic [7:0] OFS_TRANSCEIVER_MODE_CONTROL = 8'h0C;
    localparam logic [7:0] OFS_TX_STATUS = 8'h10;

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int BIT_CLOCK_OUT_ENABLE = 0;
    localparam int BIT_CLOCK_EDGE_INVERT = 1;
    localparam int BIT_SYNC_OUT_ENABLE = 2;
    localparam int BIT_SYNC_OUT_SOURCE = 3;
    localparam int BIT_AUX_SYNC_ENABLE = 4;
    localparam int BIT_LINE_DRIVER_ENABLE = 0;
    localparam int BIT_TX_POWER_DOWN = 1;
    localparam int STS_LINE_ACTIVE = 0;
    localparam int STS_LAST_BIT = 1;
    localparam int STS_CLOCK_LEVEL = 2;
    localparam int STS_AUX_SYNC_SEEN = 3;

    // =====================================================================
    // Clock source codes and output clock count
    // =====================================================================
    localparam int NUM_OUT_CLOCKS = 9;
    localparam logic [3:0] CLKSRC_AUX_PIN = 4'h0;
    localparam logic [3:0] CLKSRC_LAST_LOW = 4'h7;
    localparam logic [3:0] CLKSRC_OC9 = 4'h9;
    localparam logic [3:0] CLKSRC_RESET = 4'h1;

    typedef enum logic [1:0] {
        BTPC_MODE_DS1 = 2'b00,
        BTPC_MODE_E1 = 2'b01,
        BTPC_MODE_2048K = 2'b10,
        BTPC_MODE_6312K = 2'b11
    } btpc_mode_t;

    typedef struct packed {
        logic clock_out_enable;
        logic clock_edge_invert;
        logic sync_out_enable;
        logic sync_out_source;
        logic aux_sync_enable;
        logic [3:0] tx_clock_source;
        logic line_driver_enable;
        logic tx_power_down;
        btpc_mode_t tx_line_mode;
    } btpc_cfg_t;

    localparam btpc_cfg_t CFG_RESET = '{
        clock_out_enable: 1'b0,
        clock_edge_invert: 1'b0,
        sync_out_enable: 1'b0,
        sync_out_source: 1'b0,
        aux_sync_enable: 1'b0,
        tx_clock_source: CLKSRC_RESET,
        line_driver_enable: 1'b0,
        tx_power_down: 1'b0,
        tx_line_mode: BTPC_MODE_DS1
    };

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_AW-1:0] paddr;
        logic [APB_DW-1:0] pwdata;
    } btpc_apb_req_t;

    typedef struct packed {
        logic [APB_DW-1:0] prdata;
        logic pready;
        logic pslverr;
    } btpc_apb_rsp_t;

endpackage

// ---- core/btpc_tx_pin_ctrl.sv ----
// Transmit pin control of one timing transceiver: clock mux, sampling, sync out, line drivers.
module btpc_tx_pin_ctrl
    import btpc_pkg::*;
(
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic line_clk,
    // Register bus
    input wire btpc_apb_req_t apb_req,
    output btpc_apb_rsp_t apb_rsp,
    // Clock sources and system-side inputs
    input wire logic [NUM_OUT_CLOCKS:1] out_clk,
    input wire logic tx_aux_input,
    input wire logic tx_serial_data_in,
    input wire logic frame_sync_in,
    input wire logic mframe_sync_in,
    input wire logic ovh_slot,
    input wire logic ovh_bit,
    // System-side outputs
    output logic tx_clock_out,
    output logic tx_clock_out_oe_n,
    output logic tx_sync_out,
    output logic tx_sync_out_oe_n,
    output logic tx_bit_strobe,
    output logic aux_sync_sample,
    // Line side
    input wire logic line_float_pin,
    output logic line_out_positive,
    output logic line_out_negative,
    output logic line_out_oe_n
);

    // =====================================================================
    // Register bus slave
    // =====================================================================
    // Every bit below is local to this instance; a second instance shares nothing.
    btpc_cfg_t cfg_q, cfg_d;
    btpc_apb_rsp_t rsp_q, rsp_d;
    logic line_active_s1_q, line_active_s2_q;
    logic bit_q, sel_q, aux_seen_q, aux_seen_d;
    logic access;

    assign access = apb_req.psel && apb_req.penable && !rsp_q.pready;

    function automatic logic addr_hit(input logic [APB_AW-1:0] a);
        addr_hit = (a == OFS_TX_PIN_CONTROL) || (a == OFS_CLOCK_SELECT_CONTROL) ||
                   (a == OFS_LINE_INTERFACE_CONTROL) || (a == OFS_TRANSCEIVER_MODE_CONTROL) ||
                   (a == OFS_TX_STATUS);
    endfunction

    always_comb begin
        cfg_d = cfg_q;
        rsp_d = '0;
        if (access) begin
            rsp_d.pready = 1'b1;
            rsp_d.pslverr = !addr_hit(apb_req.paddr);
            case (apb_req.paddr)
                OFS_TX_PIN_CONTROL: begin
                    rsp_d.prdata[BIT_CLOCK_OUT_ENABLE] = cfg_q.clock_out_enable;
                    rsp_d.prdata[BIT_CLOCK_EDGE_INVERT] = cfg_q.clock_edge_invert;
                    rsp_d.prdata[BIT_SYNC_OUT_ENABLE] = cfg_q.sync_out_enable;
                    rsp_d.prdata[BIT_SYNC_OUT_SOURCE] = cfg_q.sync_out_source;
                    rsp_d.prdata[BIT_AUX_SYNC_ENABLE] = cfg_q.aux_sync_enable;
                    if (apb_req.pwrite) begin
                        cfg_d.clock_out_enable = apb_req.pwdata[BIT_CLOCK_OUT_ENABLE];
                        cfg_d.clock_edge_invert = apb_req.pwdata[BIT_CLOCK_EDGE_INVERT];
                        cfg_d.sync_out_enable = apb_req.pwdata[BIT_SYNC_OUT_ENABLE];
                        cfg_d.sync_out_source = apb_req.pwdata[BIT_SYNC_OUT_SOURCE];
                        cfg_d.aux_sync_enable = apb_req.pwdata[BIT_AUX_SYNC_ENABLE];
                    end
                end
                OFS_CLOCK_SELECT_CONTROL: begin
                    rsp_d.prdata[3:0] = cfg_q.tx_clock_source;
                    if (apb_req.pwrite) begin
                        cfg_d.tx_clock_source = apb_req.pwdata[3:0];
                    end
                end
                OFS_LINE_INTERFACE_CONTROL: begin
                    rsp_d.prdata[BIT_LINE_DRIVER_ENABLE] = cfg_q.line_driver_enable;
                    rsp_d.prdata[BIT_TX_POWER_DOWN] = cfg_q.tx_power_down;
                    if (apb_req.pwrite) begin
                        cfg_d.line_driver_enable = apb_req.pwdata[BIT_LINE_DRIVER_ENABLE];
                        cfg_d.tx_power_down = apb_req.pwdata[BIT_TX_POWER_DOWN];
                    end
                end
                OFS_TRANSCEIVER_MODE_CONTROL: begin
                    rsp_d.prdata[1:0] = cfg_q.tx_line_mode;
                    if (apb_req.pwrite) begin
                        cfg_d.tx_line_mode = btpc_mode_t'(apb_req.pwdata[1:0]);
                    end
                end
                OFS_TX_STATUS: begin
                    rsp_d.prdata[STS_LINE_ACTIVE] = line_active_s2_q;
                    rsp_d.prdata[STS_LAST_BIT] = bit_q;
                    rsp_d.prdata[STS_CLOCK_LEVEL] = sel_q;
                    rsp_d.prdata[STS_AUX_SYNC_SEEN] = aux_seen_q;
                end
                default: begin
                    rsp_d.prdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= CFG_RESET;
            rsp_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            rsp_q <= rsp_d;
        end
    end

    assign apb_rsp = rsp_q;

    // =====================================================================
    // Pin synchronisers, clock mux and sampling edge
    // =====================================================================
    // The clock, aux and serial pins pass two flops; the clock passes one more (sel_q), so the data
    // is taken one ref_clk after the edge, still inside the half period the partner holds it.
    logic [NUM_OUT_CLOCKS:1] oc_s1_q, oc_s2_q;
    logic aux_s1_q, aux_s2_q, ser_s1_q, ser_s2_q;
    logic sel_d, sel_prev_q, edge_hit, data_mode;
    logic bit_d, strobe_d, strobe_q, auxs_d, auxs_q;
    logic clk_out_d, clk_out_q, clk_oe_n_q, sync_d, sync_q, sync_oe_n_q;
    logic tgl_d, tgl_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            oc_s1_q <= '0;
            oc_s2_q <= '0;
            aux_s1_q <= 1'b0;
            aux_s2_q <= 1'b0;
            ser_s1_q <= 1'b1;
            ser_s2_q <= 1'b1;
        end else begin
            oc_s1_q <= out_clk;
            oc_s2_q <= oc_s1_q;
            aux_s1_q <= tx_aux_input;
            aux_s2_q <= aux_s1_q;
            ser_s1_q <= tx_serial_data_in;
            ser_s2_q <= ser_s1_q;
        end
    end

    assign data_mode = (cfg_q.tx_line_mode == BTPC_MODE_DS1) ||
                       (cfg_q.tx_line_mode == BTPC_MODE_E1);

    always_comb begin
        // Source 8 and codes above 9 select nothing; the clock then stays low.
        if (cfg_q.tx_clock_source == CLKSRC_AUX_PIN) begin
            sel_d = aux_s2_q;
        end else if (cfg_q.tx_clock_source <= CLKSRC_LAST_LOW ||
                     cfg_q.tx_clock_source == CLKSRC_OC9) begin
            sel_d = oc_s2_q[cfg_q.tx_clock_source];
        end else begin
            sel_d = 1'b0;
        end
        // Edge invert 0 samples on the rising edge of the clock output, 1 on the falling.
        edge_hit = cfg_q.clock_edge_invert ? (sel_prev_q && !sel_q)
                                           : (!sel_prev_q && sel_q);
        clk_out_d = sel_q && cfg_q.clock_out_enable;
        strobe_d = edge_hit;
        bit_d = bit_q;
        tgl_d = tgl_q;
        auxs_d = 1'b0;
        aux_seen_d = aux_seen_q;
        if (edge_hit) begin
            tgl_d = !tgl_q;
            if (!data_mode) begin
                bit_d = 1'b1;
            end else if (ovh_slot) begin
                bit_d = ovh_bit;
            end else begin
                bit_d = ser_s2_q;
            end
            // The aux pin carries sync only when it is not the clock source.
            if (data_mode && cfg_q.aux_sync_enable &&
                cfg_q.tx_clock_source != CLKSRC_AUX_PIN) begin
                auxs_d = aux_s2_q;
                aux_seen_d = aux_seen_q || aux_s2_q;
            end
        end
        if (access && !apb_req.pwrite && apb_req.paddr == OFS_TX_STATUS && !auxs_d) begin
            aux_seen_d = 1'b0;
        end
        sync_d = cfg_q.sync_out_source ? mframe_sync_in : frame_sync_in;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sel_q <= 1'b0;
            sel_prev_q <= 1'b0;
            clk_out_q <= 1'b0;
            clk_oe_n_q <= 1'b1;
            strobe_q <= 1'b0;
            bit_q <= 1'b1;
            tgl_q <= 1'b0;
            auxs_q <= 1'b0;
            aux_seen_q <= 1'b0;
            sync_q <= 1'b0;
            sync_oe_n_q <= 1'b1;
            line_active_s1_q <= 1'b0;
            line_active_s2_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            sel_prev_q <= sel_q;
            clk_out_q <= clk_out_d;
            clk_oe_n_q <= !cfg_q.clock_out_enable;
            strobe_q <= strobe_d;
            bit_q <= bit_d;
            tgl_q <= tgl_d;
            auxs_q <= auxs_d;
            aux_seen_q <= aux_seen_d;
            sync_q <= sync_d;
            sync_oe_n_q <= !cfg_q.sync_out_enable;
            line_active_s1_q <= !line_out_oe_n;
            line_active_s2_q <= line_active_s1_q;
        end
    end

    assign tx_clock_out = clk_out_q;
    assign tx_clock_out_oe_n = clk_oe_n_q;
    assign tx_bit_strobe = strobe_q;
    assign aux_sync_sample = auxs_q;
    assign tx_sync_out = sync_q;
    assign tx_sync_out_oe_n = sync_oe_n_q;

    // =====================================================================
    // Line domain: bit hand-over and line drivers
    // =====================================================================
    // The bit is held for a whole bit period, far longer than the toggle
    // takes to cross, so reading it on the toggle change is safe.
    logic tg_s1_q, tg_s2_q, tg_s3_q, drv_s1_q, drv_s2_q, pd_s1_q, pd_s2_q;
    logic flt_s1_q, flt_s2_q, pol_q, pol_d, pos_q, pos_d, neg_q, neg_d, oe_n_q, oe_n_d;
    logic new_bit;

    assign new_bit = tg_s2_q ^ tg_s3_q;

    always_comb begin
        pol_d = pol_q;
        pos_d = pos_q;
        neg_d = neg_q;
        oe_n_d = !(drv_s2_q && !flt_s2_q && !pd_s2_q);
        if (new_bit) begin
            pos_d = bit_q && !pol_q;
            neg_d = bit_q && pol_q;
            pol_d = pol_q ^ bit_q;
        end
        if (oe_n_d) begin
            pos_d = 1'b0;
            neg_d = 1'b0;
        end
    end

    always_ff @(posedge line_clk or negedge nrst) begin
        if (!nrst) begin
            tg_s1_q <= 1'b0;
            tg_s2_q <= 1'b0;
            tg_s3_q <= 1'b0;
            drv_s1_q <= 1'b0;
            drv_s2_q <= 1'b0;
            pd_s1_q <= 1'b1;
            pd_s2_q <= 1'b1;
            flt_s1_q <= 1'b1;
            flt_s2_q <= 1'b1;
            pol_q <= 1'b0;
            pos_q <= 1'b0;
            neg_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            tg_s1_q <= tgl_q;
            tg_s2_q <= tg_s1_q;
            tg_s3_q <= tg_s2_q;
            drv_s1_q <= cfg_q.line_driver_enable;
            drv_s2_q <= drv_s1_q;
            pd_s1_q <= cfg_q.tx_power_down;
            pd_s2_q <= pd_s1_q;
            flt_s1_q <= line_float_pin;
            flt_s2_q <= flt_s1_q;
            pol_q <= pol_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign line_out_positive = pos_q;
    assign line_out_negative = neg_q;
    assign line_out_oe_n = oe_n_q;

    // =====================================================================
    // Assertions
    // =====================================================================
    property p_clk_disabled;
        @(posedge ref_clk) disable iff (!nrst)
        !cfg_q.clock_out_enable ##1 !cfg_q.clock_out_enable |->
            tx_clock_out_oe_n && !tx_clock_out ##1 !tx_clock_out;
    endproperty
    a_clk_disabled: assert property (p_clk_disabled) else $error("clock out not disabled");

    property p_edge_choice;
        @(posedge ref_clk) disable iff (!nrst)
        (sel_q && !sel_prev_q && !cfg_q.clock_edge_invert) |=> tx_bit_strobe;
    endproperty
    a_edge_choice: assert property (p_edge_choice) else $error("rising edge not sampled");

    property p_sync_source;
        @(posedge ref_clk) disable iff (!nrst)
        cfg_q.sync_out_source && cfg_q.sync_out_enable |=>
            tx_sync_out == $past(mframe_sync_in) && !tx_sync_out_oe_n;
    endproperty
    a_sync_source: assert property (p_sync_source) else $error("sync source wrong");

    property p_aux_clock;
        @(posedge ref_clk) disable iff (!nrst)
        (cfg_q.tx_clock_source == CLKSRC_AUX_PIN) |=> sel_q == $past(aux_s2_q);
    endproperty
    a_aux_clock: assert property (p_aux_clock) else $error("aux pin not used as clock");

    property p_aux_sync_mode;
        @(posedge ref_clk) disable iff (!nrst)
        aux_sync_sample |-> $past(data_mode) && $past(strobe_d);
    endproperty
    a_aux_sync_mode: assert property (p_aux_sync_mode) else $error("aux sync bad sample");

    property p_payload;
        @(posedge ref_clk) disable iff (!nrst)
        (edge_hit && data_mode && !ovh_slot) |=> bit_q == $past(ser_s2_q) ##1 tx_bit_strobe == 1'b0;
    endproperty
    a_payload: assert property (p_payload) else $error("payload bit not sampled");

    property p_overhead;
        @(posedge ref_clk) disable iff (!nrst)
        (edge_hit && data_mode && ovh_slot) |=> bit_q == $past(ovh_bit);
    endproperty
    a_overhead: assert property (p_overhead) else $error("overhead bit not inserted");

    property p_ignore_serial;
        @(posedge ref_clk) disable iff (!nrst)
        (edge_hit && !data_mode) |=> bit_q;
    endproperty
    a_ignore_serial: assert property (p_ignore_serial) else $error("serial input not ignored");

    property p_float;
        @(posedge line_clk) disable iff (!nrst)
        (flt_s2_q || !drv_s2_q) |=> line_out_oe_n && !line_out_positive && !line_out_negative;
    endproperty
    a_float: assert property (p_float) else $error("line outputs not floated");

    property p_power_down;
        @(posedge line_clk) disable iff (!nrst)
        pd_s2_q [*2] |-> line_out_oe_n;
    endproperty
    a_power_down: assert property (p_power_down) else $error("line driven in power down");

endmodule
